/* File: hw/ssp_port.sv */
/*
 * Serial programming slave: samples the programmer's clock, reset and data
 * pins, decodes four-byte frames and drives program/data memories held here.
 * Assumes all pins are asynchronous to clk_sys and the link clock's phases
 * last at least three system clocks.
 */
`timescale 1ns/10ps
`include "ssp_consts.svh"

module ssp_port
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic porn,
    input  wire logic progResetN,
    input  wire logic progClk,
    input  wire logic prog_serial_in,
    input  wire logic program_enable_pin_n,
    output logic      prog_serial_out,
    output logic      progMode,
    output logic      progEnabled,
    output logic      writeBusy
);
    localparam int PAGE_CYC  = `SSP_US_TO_CYC(`SSP_PAGE_WRITE_US);
    localparam int DATA_CYC  = `SSP_US_TO_CYC(`SSP_DATA_WRITE_US);
    localparam int FUSE_CYC  = `SSP_US_TO_CYC(`SSP_FUSE_WRITE_US);
    localparam int ERASE_CYC = `SSP_US_TO_CYC(`SSP_ERASE_US);

    // Two-flop synchronisers on every pin
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;
    logic       clkOld_q;
    always_ff @(posedge clk_sys)
    begin
        syncA_q <= {progClk, prog_serial_in, progResetN, program_enable_pin_n};
        syncB_q <= syncA_q;
        clkOld_q <= syncB_q[3];
    end
    logic sck;
    logic sdi;
    logic resetLow;
    logic penN;
    assign sck      = syncB_q[3];
    assign sdi      = syncB_q[2];
    assign resetLow = ~syncB_q[1];
    assign penN     = syncB_q[0];
    logic riseSck;
    logic fallSck;
    assign riseSck = sck & ~clkOld_q;
    assign fallSck = ~sck & clkOld_q;

    // Power-on entry: pin caught in the first cycle after power-on reset
    logic porSeen_q;
    logic penMode_q;
    always_ff @(posedge clk_sys)
    begin
        if (!porn)
        begin
            porSeen_q <= 1'b0;
            penMode_q <= 1'b0;
        end
        else if (!porSeen_q)
        begin
            porSeen_q <= 1'b1;
            penMode_q <= ~penN & ~sck;
        end
    end

    // Session active while reset held low, or once pin-entered until the next power-on reset
    logic session;
    assign session = resetLow | penMode_q;
    assign progMode = session;

    // Frame shifter
    logic [4:0]       bitCnt_q;
    logic [31:0]      shIn_q;
    logic [7:0]       shOut_q;
    logic             frameDone;
    ssp_pkg::ssp_frame_t frame;
    assign frame = ssp_pkg::ssp_frame_t'({shIn_q[30:0], sdi});
    assign frameDone = riseSck && bitCnt_q == 5'd31;

    logic [7:0] readByte;
    logic       loadOut;
    logic [7:0] loadVal;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !session)
        begin
            bitCnt_q <= 5'd0;
            shIn_q   <= 32'h0;
        end
        else if (riseSck)
        begin
            shIn_q   <= {shIn_q[30:0], sdi};
            bitCnt_q <= bitCnt_q + 5'd1;
        end
    end

    // Output byte: loaded at byte boundaries, shifted on falls
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !session)
            shOut_q <= 8'h00;
        else if (loadOut)
            shOut_q <= loadVal;
        else if (fallSck && bitCnt_q[2:0] != 3'd0)
            shOut_q <= {shOut_q[6:0], 1'b0};
    end
    assign prog_serial_out = shOut_q[7];

    // Byte boundary detection: after the 8th, 16th and 24th rise, reload on the next fall
    logic boundary;
    assign boundary = fallSck && bitCnt_q[2:0] == 3'd0 && bitCnt_q != 5'd0;
    assign loadOut  = boundary;

    // Output byte choice by index of the byte about to be shifted
    always_comb
    begin
        loadVal = 8'h00;
        if (bitCnt_q == 5'd16)
            loadVal = shIn_q[7:0];
        else if (bitCnt_q == 5'd24)
            loadVal = readByte;
    end

    // Enabled after a valid enable frame in this session
    logic syncOk;
    assign syncOk = frame.op == `SSP_OP_ENABLE && frame.b2 == `SSP_ENABLE_ECHO;
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !session)
            progEnabled <= 1'b0;
        else if (frameDone && syncOk && resetLow | penMode_q)
            progEnabled <= 1'b1;
    end

    // Memories
    logic [7:0] progLo [`SSP_PROG_WORDS*`SSP_PAGE_WORDS];
    logic [7:0] progHi [`SSP_PROG_WORDS*`SSP_PAGE_WORDS];
    logic [7:0] dataMem [`SSP_DATA_BYTES];
    logic [7:0] pageLo [`SSP_PAGE_WORDS];
    logic [7:0] pageHi [`SSP_PAGE_WORDS];
    logic [7:0] fuseLo_q;
    logic [7:0] fuseHi_q;

    ssp_pkg::ssp_busy_t busy_q;
    logic [17:0]        busyCnt_q;
    logic [8:0]         busyPage_q;
    logic [10:0]        busyAddr_q;
    logic [15:0]        eraseIdx_q;
    assign writeBusy = busy_q != ssp_pkg::SSP_IDLE;

    // Decoded addresses of the current frame (bytes 2..3, used at the 32nd rise)
    logic [15:0] wordAddr;
    logic [10:0] dataAddr;
    assign wordAddr = {frame.b2, frame.b3};
    assign dataAddr = {frame.b2[2:0], frame.b3};

    // Read data, sampled when byte 3 has arrived; partAddr = {b2,b3}
    logic [15:0] partAddr;
    assign partAddr = shIn_q[15:0];
    always_comb
    begin
        readByte = `SSP_ERASED;
        case (shIn_q[23:16])
            `SSP_OP_READ_PROG, `SSP_OP_READ_PROG | 8'h08:
                if (!(busy_q == ssp_pkg::SSP_PAGE_WR && partAddr[15:7] == busyPage_q))
                    readByte = shIn_q[19] ? progHi[partAddr] : progLo[partAddr];
            `SSP_OP_READ_DATA:
                if (!(busy_q == ssp_pkg::SSP_DATA_WR && partAddr[10:0] == busyAddr_q))
                    readByte = dataMem[partAddr[10:0]];
            `SSP_OP_READ_FUSE:
                readByte = partAddr[11] ? `SSP_ERASED : fuseLo_q;
            `SSP_OP_READ_FUSE_HI:
                readByte = fuseHi_q;
            default:
                readByte = `SSP_ERASED;
        endcase
    end

    // Execution of completed frames and self-timed writes
    logic exec;
    assign exec = frameDone && progEnabled && busy_q == ssp_pkg::SSP_IDLE;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            busy_q     <= ssp_pkg::SSP_IDLE;
            busyCnt_q  <= 18'd0;
            busyPage_q <= 9'd0;
            busyAddr_q <= 11'd0;
            eraseIdx_q <= 16'd0;
            fuseLo_q   <= `SSP_FUSE_LO_RESET;
            fuseHi_q   <= `SSP_FUSE_HI_RESET;
        end
        else
        begin
            case (busy_q)
                ssp_pkg::SSP_IDLE:
                    if (exec)
                    begin
                        case (frame.op)
                            `SSP_OP_LOAD_PAGE:
                                pageLo[frame.b3[6:0]] <= frame.b4;
                            `SSP_OP_LOAD_PAGE | 8'h08:
                                pageHi[frame.b3[6:0]] <= frame.b4;
                            `SSP_OP_WRITE_PAGE:
                            begin
                                busyPage_q <= wordAddr[15:7];
                                busyCnt_q  <= 18'(PAGE_CYC);
                                busy_q     <= ssp_pkg::SSP_PAGE_WR;
                            end
                            `SSP_OP_WRITE_DATA:
                            begin
                                busyAddr_q <= dataAddr;
                                dataMem[dataAddr] <= frame.b4;
                                busyCnt_q  <= 18'(DATA_CYC);
                                busy_q     <= ssp_pkg::SSP_DATA_WR;
                            end
                            `SSP_OP_ENABLE:
                                if (frame.b2[7:5] == `SSP_ERASE_B2_TOP)
                                begin
                                    eraseIdx_q <= 16'd0;
                                    busyCnt_q  <= 18'(ERASE_CYC);
                                    busy_q     <= ssp_pkg::SSP_ERASE;
                                end
                                else if (frame.b2 == `SSP_FUSE_B2_LO ||
                                         frame.b2 == `SSP_FUSE_B2_HI)
                                begin
                                    if (frame.b2 == `SSP_FUSE_B2_LO)
                                        fuseLo_q <= frame.b4;
                                    else
                                        fuseHi_q <= frame.b4;
                                    busyCnt_q <= 18'(FUSE_CYC);
                                    busy_q    <= ssp_pkg::SSP_FUSE_WR;
                                end
                            default:
                                ;
                        endcase
                    end
                ssp_pkg::SSP_PAGE_WR:
                begin
                    // Page copy one word per cycle, well inside the write time
                    if (busyCnt_q > 18'(PAGE_CYC - `SSP_PAGE_WORDS))
                    begin
                        progLo[{busyPage_q, 7'(PAGE_CYC - busyCnt_q)}] <=
                            pageLo[7'(PAGE_CYC - busyCnt_q)];
                        progHi[{busyPage_q, 7'(PAGE_CYC - busyCnt_q)}] <=
                            pageHi[7'(PAGE_CYC - busyCnt_q)];
                    end
                    busyCnt_q <= busyCnt_q - 18'd1;
                    if (busyCnt_q == 18'd1)
                        busy_q <= ssp_pkg::SSP_IDLE;
                end
                ssp_pkg::SSP_ERASE:
                begin
                    // One location per cycle; 64K words fit in the erase time
                    progLo[eraseIdx_q] <= `SSP_ERASED;
                    progHi[eraseIdx_q] <= `SSP_ERASED;
                    dataMem[eraseIdx_q[10:0]] <= `SSP_ERASED;
                    eraseIdx_q <= eraseIdx_q + 16'd1;
                    busyCnt_q <= busyCnt_q - 18'd1;
                    if (busyCnt_q == 18'd1)
                        busy_q <= ssp_pkg::SSP_IDLE;
                end
                default:
                begin
                    busyCnt_q <= busyCnt_q - 18'd1;
                    if (busyCnt_q == 18'd1)
                        busy_q <= ssp_pkg::SSP_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: pkg/ssp_consts.svh */
/*
 * Constants of the serial programming port: instruction codes, memory sizes,
 * erased value, echo value and self-timed write durations.
 * Assumes a 20 MHz system clock; times are in microseconds.
 */
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_CLK_MHZ          20
`define SSP_OP_ENABLE        8'hac
`define SSP_ENABLE_ECHO      8'h53
`define SSP_OP_READ_PROG     8'h20
`define SSP_OP_LOAD_PAGE     8'h40
`define SSP_OP_WRITE_PAGE    8'h4c
`define SSP_OP_READ_DATA     8'ha0
`define SSP_OP_WRITE_DATA    8'hc0
`define SSP_OP_READ_FUSE     8'h50
`define SSP_OP_READ_FUSE_HI  8'h58
`define SSP_ERASE_B2_TOP     3'h4
`define SSP_FUSE_B2_LO       8'ha0
`define SSP_FUSE_B2_HI       8'ha8
`define SSP_ERASED           8'hff
`define SSP_FUSE_LO_RESET    8'he1
`define SSP_FUSE_HI_RESET    8'h99
`define SSP_PROG_WORDS       512
`define SSP_PAGE_WORDS       128
`define SSP_DATA_BYTES       2048
`define SSP_PAGE_WRITE_US    4500
`define SSP_DATA_WRITE_US    9000
`define SSP_FUSE_WRITE_US    4500
`define SSP_ERASE_US         9000
`define SSP_US_TO_CYC(t)     ((t) * `SSP_CLK_MHZ)

`endif

/* File: pkg/ssp_pkg.sv */
/*
 * Types of the serial programming port.
 * Assumes ssp_consts.svh for all figures.
 */
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE,
        SSP_PAGE_WR,
        SSP_DATA_WR,
        SSP_FUSE_WR,
        SSP_ERASE
    } ssp_busy_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } ssp_frame_t;
endpackage

/* File: verif/ssp_port_assertions.sv */
/* Checker for the pins of ssp_port.
   Assumes one clk_sys domain and is bound to every ssp_port. */
`timescale 1ns/10ps
`include "ssp_consts.svh"
module ssp_port_assertions
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic porn,
    input wire logic progResetN,
    input wire logic progClk,
    input wire logic prog_serial_in,
    input wire logic program_enable_pin_n,
    input wire logic prog_serial_out,
    input wire logic progMode,
    input wire logic progEnabled,
    input wire logic writeBusy
);
    logic        pornSeen_q;
    logic        pinEntry_q;
    logic [17:0] busyCnt_q;
    // Shortest self-timed write, less the sampling cycle of the fall
    localparam int MIN_BUSY = `SSP_US_TO_CYC(`SSP_PAGE_WRITE_US) - 1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys)
    begin
        pornSeen_q <= porn;
    end
    // Only a power-down clears a pin-entered session
    always_ff @(posedge clk_sys)
    begin
        if (!porn)
            pinEntry_q <= 1'b0;
        else if (!pornSeen_q && !program_enable_pin_n)
            pinEntry_q <= 1'b1;
    end
    always_ff @(posedge clk_sys)
    begin
        busyCnt_q <= writeBusy ? busyCnt_q + 18'h00001 : 18'h00000;
    end
    sequence s_pinEntry;
        $rose(porn) && !program_enable_pin_n;
    endsequence
    sequence s_outMove;
        progMode && $past(progMode) && $changed(prog_serial_out);
    endsequence
    a_pin_entry: assert property (s_pinEntry |-> ##[1:4] progMode)
        else $error("entry pin opened no session");
    a_pin_held: assert property (pinEntry_q && $past(pinEntry_q, 4) |-> progMode)
        else $error("pin session ended early");
    // Sync delay puts the move a few cycles after the fall
    a_out_on_fall: assert property (s_outMove |-> !$past(progClk, 2))
        else $error("data out moved outside clock low");
    a_enable_in_mode: assert property ($rose(progEnabled) |-> progMode)
        else $error("enabled outside a session");
    a_leave_on_release: assert property ($fell(progMode) |-> ##[0:3] !progEnabled)
        else $error("enable kept after session end");
    a_no_mode_idle: assert property (!progMode [*3] |-> !progEnabled)
        else $error("enabled with no session");
    a_busy_needs_enable: assert property ($rose(writeBusy) |-> $past(progEnabled))
        else $error("write started before enable");
    a_busy_min_time: assert property ($fell(writeBusy) |-> $past(busyCnt_q) >= 18'(MIN_BUSY))
        else $error("self-timed write too short");
endmodule
bind ssp_port ssp_port_assertions i_chk
(
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .porn                 (porn),
    .progResetN           (progResetN),
    .progClk              (progClk),
    .prog_serial_in       (prog_serial_in),
    .program_enable_pin_n (program_enable_pin_n),
    .prog_serial_out      (prog_serial_out),
    .progMode             (progMode),
    .progEnabled          (progEnabled),
    .writeBusy            (writeBusy)
);

/* File: verif/ssp_programmer.sv */
/* Programmer model driving reset, link clock and data in.
   Assumes the bench calls its tasks by hierarchical name. */
`timescale 1ns/10ps
module ssp_programmer
#(
    parameter int ENABLE_WAIT_NS = 20000
)
(
    input  wire logic prog_serial_out,
    output logic      progClk,
    output logic      prog_serial_in,
    output logic      progResetN
);
    initial
    begin
        progClk = 1'b0;
        progResetN = 1'b0;
        prog_serial_in = 1'b0;
    end
    task automatic open_session();
        #7;
        progResetN = 1'b1;
        #100;
        progResetN = 1'b0;
        #(ENABLE_WAIT_NS);
    endtask
    task automatic close_session();
        #7;
        progResetN = 1'b1;
        #200;
    endtask
    // Clock stands low between frames; sample late in the high phase
    task automatic xfer(input ssp_pkg::ssp_frame_t tx, output ssp_pkg::ssp_frame_t rx);
        #7;
        for (int i = 31; i >= 0; i--)
        begin
            prog_serial_in = tx[i];
            #200 progClk = 1'b1;
            #190 rx[i] = prog_serial_out;
            #10 progClk = 1'b0;
        end
        prog_serial_in = ~prog_serial_in;
    endtask
endmodule

/* File: verif/ssp_port_bench.sv */
/* Bench for ssp_port with the programmer model on its serial pins.
   Assumes the checker binds itself; session wait shortened to 20 us. */
`timescale 1ns/10ps
`include "ssp_consts.svh"
module ssp_port_bench;
    logic                clk_sys;
    logic                rstn;
    logic                porn;
    logic                program_enable_pin_n;
    logic                progClk;
    logic                prog_serial_in;
    logic                progResetN;
    logic                prog_serial_out;
    logic                progMode;
    logic                progEnabled;
    logic                writeBusy;
    ssp_pkg::ssp_frame_t rx;
    int                  fails;
    int                  check_count;
    ssp_port i_dut
    (
        .clk_sys              (clk_sys),
        .rstn                 (rstn),
        .porn                 (porn),
        .progResetN           (progResetN),
        .progClk              (progClk),
        .prog_serial_in       (prog_serial_in),
        .program_enable_pin_n (program_enable_pin_n),
        .prog_serial_out      (prog_serial_out),
        .progMode             (progMode),
        .progEnabled          (progEnabled),
        .writeBusy            (writeBusy)
    );
    ssp_programmer #(.ENABLE_WAIT_NS(20000)) i_prog
    (
        .prog_serial_out (prog_serial_out),
        .progClk         (progClk),
        .prog_serial_in  (prog_serial_in),
        .progResetN      (progResetN)
    );
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic test_pin_entry();
        i_prog.close_session();
        tick(1);
        // Pin held low through the whole power-on reset, past its synchroniser
        porn <= 1'b0;
        program_enable_pin_n <= 1'b0;
        tick(4);
        porn <= 1'b1;
        tick(4);
        checkBit(progMode, 1'b1);
        rstn <= 1'b0;
        program_enable_pin_n <= 1'b1;
        tick(2);
        rstn <= 1'b1;
        tick(4);
        checkBit(progMode, 1'b1);
        porn <= 1'b0;
        tick(1);
        porn <= 1'b1;
        tick(4);
        checkBit(progMode, 1'b0);
        $display("pin entry done");
    endtask
    task automatic test_enable();
        i_prog.open_session();
        i_prog.xfer({`SSP_OP_WRITE_PAGE, 24'h000000}, rx);
        tick(6);
        checkBit(writeBusy, 1'b0);
        // Enable frame one bit late: framing out of step
        i_prog.xfer(32'h5629_8000, rx);
        tick(6);
        checkBit(progEnabled, 1'b0);
        i_prog.xfer({`SSP_OP_ENABLE, `SSP_ENABLE_ECHO, 16'h0000}, rx);
        check8(rx.b3, `SSP_ENABLE_ECHO);
        tick(6);
        checkBit(progEnabled, 1'b1);
        i_prog.xfer({`SSP_OP_READ_FUSE, 24'h000000}, rx);
        check8(rx.b4, `SSP_FUSE_LO_RESET);
        i_prog.xfer({`SSP_OP_READ_FUSE_HI, 24'h080000}, rx);
        check8(rx.b4, `SSP_FUSE_HI_RESET);
        $display("enable done");
    endtask
    task automatic test_page();
        int n;
        n = 0;
        i_prog.xfer({`SSP_OP_LOAD_PAGE, 16'h0003, 8'h12}, rx);
        i_prog.xfer({`SSP_OP_LOAD_PAGE | 8'h08, 16'h0003, 8'h34}, rx);
        i_prog.xfer({`SSP_OP_WRITE_PAGE, 24'h000000}, rx);
        tick(6);
        checkBit(writeBusy, 1'b1);
        i_prog.xfer({`SSP_OP_READ_PROG, 24'h000300}, rx);
        check8(rx.b4, `SSP_ERASED);
        while (writeBusy !== 1'b0 && n < 100000)
        begin
            tick(1);
            n++;
        end
        checkBit(writeBusy, 1'b0);
        i_prog.xfer({`SSP_OP_READ_PROG, 24'h000300}, rx);
        check8(rx.b4, 8'h12);
        i_prog.xfer({`SSP_OP_READ_PROG | 8'h08, 24'h000300}, rx);
        check8(rx.b4, 8'h34);
        $display("page done");
    endtask
    task automatic test_data();
        i_prog.xfer({`SSP_OP_WRITE_DATA, 16'h0105, 8'h5a}, rx);
        tick(6);
        checkBit(writeBusy, 1'b1);
        i_prog.xfer({`SSP_OP_READ_DATA, 24'h010500}, rx);
        check8(rx.b4, `SSP_ERASED);
        i_prog.close_session();
        tick(4);
        checkBit(progMode, 1'b0);
        checkBit(progEnabled, 1'b0);
        $display("data and release done");
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        // Page write time dominates the run; the rest fits in the margin
        tick(`SSP_US_TO_CYC(`SSP_PAGE_WRITE_US) + 8000);
        fails++;
        conclude();
    end
    initial
    begin
        rstn = 1'b0;
        porn = 1'b0;
        program_enable_pin_n = 1'b1;
        fails = 0;
        check_count = 0;
        tick(10);
        rstn <= 1'b1;
        porn <= 1'b1;
        test_pin_entry();
        test_enable();
        test_page();
        test_data();
        conclude();
    end
endmodule
